//--- pmwc_map.svh
// constants for the power mode and wake controller
// Notes on behaviour
// R1 - clock select picks normal or slow mode
// R2 - clock select works only in fast-rc plus crystal
// R3 - slow crystal only with internal fast rc
// R4 - sleep always stops the fast clock
// R5 - slow crystal runs; slow mode stops fast rc
// R6 - halt enters sleep regardless of clock select
// R7 - sleep stops execution, keeps memory and registers
// R8 - sleep clears watchdog; slow clocks keep counting
// R9 - watchdog halts in sleep on system clock
// R10 - ports hold output and direction in sleep
// R11 - sleep sets powerdown, clears timeout flag
// R12 - wake on reset, port edge, interrupt, watchdog
// R13 - reset wake full reset; watchdog wake watchdog reset
// R14 - powerdown cleared by power-up and clear-watchdog
// R15 - watchdog wake sets timeout, resets pc and sp
// R16 - enabled port pin falling edge wakes, resumes
// R17 - masked or stack-full interrupt resumes, serviced later
// R18 - enabled interrupt with stack room gets response
// R19 - flag pending at sleep entry blocks its wake
// R20 - wake waits start-up; reset adds reset delay
// R21 - rc start-up is 2 or 1024 cycles
// R22 - crystal start-up is 1024 cycles
// R23 - slow internal rc keeps running in sleep
// R24 - software should set crystal low-power bit
// R25 - low-power bit clears at power-on
// R26 - rc start-up choice is a build parameter
`ifndef PMWC_MAP_SVH
`define PMWC_MAP_SVH
`define PMWC_CLK_MHZ          100
`define PMWC_RESET_DELAY_MS   100
`define PMWC_RESET_DELAY_CYC  (`PMWC_RESET_DELAY_MS * 1000 * `PMWC_CLK_MHZ)
`define PMWC_SST_LONG_CYC     1024
`define PMWC_SST_SHORT_CYC    2
`define PMWC_CNT_W            24
`endif

//--- pmwc_partner.sv
// core and wake pin model facing the power mode and wake controller
`timescale 1ns/1ps
module pmwc_partner (
    // clock
    input  wire logic       CLOCK_I,
    // core strobe and pins
    output logic            HALT_O,
    output logic [7:0]      PORT_A_O,
    output logic            RESET_PIN_N_O
);
    // pins rest high as on pull-ups, so a released pin never floats
    initial
    begin
        HALT_O        = 1'b0;
        PORT_A_O      = 8'hff;
        RESET_PIN_N_O = 1'b1;
    end
    // one halt instruction, a single-cycle strobe launched off the falling edge
    task automatic halt();
        @(negedge CLOCK_I) HALT_O = 1'b1;
        @(negedge CLOCK_I) HALT_O = 1'b0;
    endtask : halt
    // low long enough for the two-stage synchroniser, then back to idle
    task automatic pin_pulse(input logic [2:0] b);
        @(negedge CLOCK_I) PORT_A_O[b] = 1'b0;
        repeat (4) @(negedge CLOCK_I);
        PORT_A_O[b] = 1'b1;
    endtask : pin_pulse
    // external reset pin held low for a few cycles
    task automatic reset_pulse();
        @(negedge CLOCK_I) RESET_PIN_N_O = 1'b0;
        repeat (4) @(negedge CLOCK_I);
        RESET_PIN_N_O = 1'b1;
    endtask : reset_pulse
endmodule : pmwc_partner

//--- pmwc_pkg.sv
// types for the power mode and wake controller
package pmwc_pkg;
    typedef enum logic [1:0] {PMWC_OSC_HXT_CFG, PMWC_OSC_ERC_CFG, PMWC_OSC_RC_CFG,
                              PMWC_OSC_RC_XT_CFG} pmwc_osc_t;
    typedef enum logic [1:0] {PMWC_WDCK_SLOW_RC, PMWC_WDCK_CRYSTAL,
                              PMWC_WDCK_SYS} pmwc_wdck_t;
    typedef enum {PMWC_RUN, PMWC_SLEEP, PMWC_RSTDLY, PMWC_START} pmwc_state_t;
    typedef enum logic [1:0] {PMWC_WK_NONE, PMWC_WK_RESET, PMWC_WK_PORT_INT,
                              PMWC_WK_WDT} pmwc_wake_t;
    // oscillator run controls
    typedef struct packed {
        logic fast_run;
        logic slow_xt_run;
        logic slow_rc_run;
        logic sysclk_slow;
    } pmwc_osc_ctl_t;
    typedef struct packed {
        pmwc_state_t st;
        logic [23:0] cnt;
        logic        ext_rst_dly;
        pmwc_wake_t  wake_src;
        logic [7:0]  port_prev;
        logic [7:0]  irq_block;
        logic        powerdown;
        logic        timeout;
        logic        slow_lp;
        logic        rst_pulse;
        logic        wdt_rst;
        logic        resume;
        logic        irq_resp;
    } pmwc_regs_t;
endpackage : pmwc_pkg

//--- pmwc_top.sv
// power mode, sleep and wake sequencer
`timescale 1ns/1ps
`include "pmwc_map.svh"
module pmwc_top
    import pmwc_pkg::*;
#(
    parameter bit          RC_LONG_START = 1'b1, // rc start-up 1024 when set, else 2
    parameter logic [23:0] RESET_DLY_CYC = 24'(`PMWC_RESET_DELAY_CYC)
)(
    // clock and reset
    input  wire logic        CLOCK_I,
    input  wire logic        ARST_N_I,
    // configuration
    input  wire pmwc_osc_t   OSC_CFG_I,
    input  wire pmwc_wdck_t  WDT_CLK_CFG_I,
    input  wire logic        SLOW_RC_EN_I,
    // software control bits
    input  wire logic        SYS_CLOCK_SELECT_I,
    input  wire logic        SLOW_LP_WR_I,
    input  wire logic        SLOW_LP_VAL_I,
    input  wire logic        CLR_WDT_I,
    // core events
    input  wire logic        HALT_I,
    input  wire logic [7:0]  IRQ_FLAG_I,
    input  wire logic        IRQ_ENABLE_I,
    input  wire logic        STACK_FULL_I,
    input  wire logic        WDT_OVF_I,
    // pins
    input  wire logic        EXT_RESET_PIN_N_I,
    input  wire logic [7:0]  PORT_A_I,
    input  wire logic [7:0]  PORT_WAKE_ENABLE_I,
    // outputs
    output pmwc_osc_ctl_t    OSC_CTL_O,
    output logic             CORE_RUN_O,
    output logic             SLEEPING_O,
    output logic             PORT_HOLD_O,
    output logic             WDT_CLEAR_O,
    output logic             WDT_RUN_O,
    output logic             POWERDOWN_FLAG_O,
    output logic             TIMEOUT_FLAG_O,
    output logic             SLOW_CRYSTAL_LOWPOWER_O,
    output logic             FULL_RESET_O,
    output logic             WDT_RESET_O,
    output logic             RESUME_O,
    output logic             IRQ_RESPONSE_O
);
    // pin synchronisers, first stage read only by second;
    // both stages reset high so idle pull-ups give no false edge after reset
    logic [8:0] sync1_r;
    logic [8:0] sync2_r;
    always_ff @(posedge CLOCK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            sync1_r <= 9'h1ff;
            sync2_r <= 9'h1ff;
        end
        else
        begin
            sync1_r <= {EXT_RESET_PIN_N_I, PORT_A_I};
            sync2_r <= sync1_r;
        end
    end
    logic       rst_pin_n;
    logic [7:0] port_s;
    assign rst_pin_n = sync2_r[8];
    assign port_s    = sync2_r[7:0];

    // start-up length by oscillator kind
    // only the fast crystal has a fixed long start; rc kinds follow the build choice
    function automatic logic [23:0] sst_cycles(input pmwc_osc_t osc);
        if (osc == PMWC_OSC_HXT_CFG)
            sst_cycles = 24'(`PMWC_SST_LONG_CYC);                      // R22
        else if (RC_LONG_START)
            sst_cycles = 24'(`PMWC_SST_LONG_CYC);                      // R21 R26
        else
            sst_cycles = 24'(`PMWC_SST_SHORT_CYC);                     // R21 R26
    endfunction : sst_cycles

    pmwc_regs_t r_r;
    pmwc_regs_t r_nxt;
    logic       dual_osc;
    logic [7:0] port_fall;
    logic       port_wake;
    logic       irq_wake;
    logic       in_sleep;
    assign dual_osc  = (OSC_CFG_I == PMWC_OSC_RC_XT_CFG);             // R2 R3
    assign port_fall = r_r.port_prev & ~port_s & PORT_WAKE_ENABLE_I;  // R16
    assign port_wake = |port_fall;
    // a flag already up at halt is masked until the core runs again
    assign irq_wake  = |(IRQ_FLAG_I & ~r_r.irq_block);                // R19
    assign in_sleep  = (r_r.st == PMWC_SLEEP);

    // next-state logic for the whole sequencer
    // pulses default low so each one stands for exactly one cycle
    always_comb
    begin
        r_nxt           = r_r;
        r_nxt.port_prev = port_s;
        r_nxt.rst_pulse = 1'b0;
        r_nxt.wdt_rst   = 1'b0;
        r_nxt.resume    = 1'b0;
        r_nxt.irq_resp  = 1'b0;
        if (SLOW_LP_WR_I)
            r_nxt.slow_lp = SLOW_LP_VAL_I;                             // R25
        if (CLR_WDT_I && !in_sleep)
            r_nxt.powerdown = 1'b0;                                    // R14
        case (r_r.st)
            PMWC_RUN:
            begin
                if (HALT_I)                                            // R6 R7
                begin
                    r_nxt.st        = PMWC_SLEEP;
                    r_nxt.powerdown = 1'b1;                            // R11 R14
                    r_nxt.timeout   = 1'b0;                            // R11
                    r_nxt.irq_block = IRQ_FLAG_I;                      // R19
                end
            end
            PMWC_SLEEP:
            begin
                r_nxt.cnt = sst_cycles(OSC_CFG_I);
                // reset wins over the watchdog, the watchdog over port and interrupt
                if (!rst_pin_n)                                        // R12 R13
                begin
                    r_nxt.st          = PMWC_RSTDLY;
                    r_nxt.wake_src    = PMWC_WK_RESET;
                    r_nxt.rst_pulse   = 1'b1;
                    r_nxt.powerdown   = 1'b0;
                    r_nxt.timeout     = 1'b0;
                    r_nxt.cnt         = RESET_DLY_CYC;                 // R20
                end
                else if (WDT_OVF_I && WDT_CLK_CFG_I != PMWC_WDCK_SYS)  // R12 R15
                begin
                    r_nxt.st       = PMWC_START;
                    r_nxt.wake_src = PMWC_WK_WDT;
                    r_nxt.timeout  = 1'b1;                             // R15
                end
                else if (port_wake || irq_wake)                        // R12 R16
                begin
                    r_nxt.st       = PMWC_START;
                    r_nxt.wake_src = PMWC_WK_PORT_INT;
                end
            end
            PMWC_RSTDLY:
            begin
                if (r_r.cnt <= 24'h000001)                             // R20
                begin
                    r_nxt.st  = PMWC_START;
                    r_nxt.cnt = sst_cycles(OSC_CFG_I);
                end
                else
                    r_nxt.cnt = r_r.cnt - 24'h000001;
            end
            PMWC_START:
            begin
                if (r_r.cnt <= 24'h000001)                             // R20 R21 R22
                begin
                    r_nxt.st        = PMWC_RUN;
                    // drop the entry mask so a fresh request can wake the next sleep
                    r_nxt.irq_block = 8'h00;
                    r_nxt.wdt_rst   = (r_r.wake_src == PMWC_WK_WDT);  // R13 R15
                    r_nxt.resume    = (r_r.wake_src == PMWC_WK_PORT_INT);
                    r_nxt.irq_resp  = (r_r.wake_src == PMWC_WK_PORT_INT) && irq_wake
                                      && IRQ_ENABLE_I && !STACK_FULL_I; // R17 R18
                    r_nxt.wake_src  = PMWC_WK_NONE;
                end
                else
                    r_nxt.cnt = r_r.cnt - 24'h000001;
            end
            default:
                r_nxt.st = PMWC_RUN;
        endcase
    end

    // state register; power-on clears flags and low-power bit
    // reset values are constants only; nothing from the pins reaches this branch
    always_ff @(posedge CLOCK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            r_r <= '{st: PMWC_RUN, wake_src: PMWC_WK_NONE, port_prev: 8'hff,
                     default: '0};                                    // R14 R25
        else
            r_r <= r_nxt;
    end

    // oscillator and core controls
    // the slow crystal shares the oscillator pins, so only the dual kind runs it
    always_comb
    begin
        OSC_CTL_O.sysclk_slow = dual_osc && SYS_CLOCK_SELECT_I;        // R1 R2
        OSC_CTL_O.fast_run    = !in_sleep && !OSC_CTL_O.sysclk_slow;   // R4 R5
        OSC_CTL_O.slow_xt_run = dual_osc;                              // R3 R5
        OSC_CTL_O.slow_rc_run = SLOW_RC_EN_I;                          // R23
    end
    assign CORE_RUN_O  = (r_r.st == PMWC_RUN);                         // R7
    assign SLEEPING_O  = in_sleep;
    assign PORT_HOLD_O = (r_r.st != PMWC_RUN);                         // R10
    assign WDT_CLEAR_O = (r_r.st == PMWC_RUN) && HALT_I;               // R8
    assign WDT_RUN_O   = !(in_sleep && WDT_CLK_CFG_I == PMWC_WDCK_SYS); // R8 R9
    assign POWERDOWN_FLAG_O        = r_r.powerdown;
    assign TIMEOUT_FLAG_O          = r_r.timeout;
    assign SLOW_CRYSTAL_LOWPOWER_O = r_r.slow_lp;
    assign FULL_RESET_O            = r_r.rst_pulse;
    assign WDT_RESET_O             = r_r.wdt_rst;
    assign RESUME_O                = r_r.resume;
    assign IRQ_RESPONSE_O          = r_r.irq_resp;

    // checks
    sequence s_halt_taken;
        (r_r.st == PMWC_RUN) && HALT_I;
    endsequence
    chk_halt_flags: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // R11
        s_halt_taken |=> in_sleep && POWERDOWN_FLAG_O && !TIMEOUT_FLAG_O)
        else $error("halt did not set sleep flags");
    chk_sleep_fast_off: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // R4
        in_sleep |-> !OSC_CTL_O.fast_run) else $error("fast clock runs in sleep");
    chk_sel_ignored: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // R2
        !dual_osc |-> !OSC_CTL_O.sysclk_slow) else $error("select acted outside dual");
    chk_wdt_sys_halt: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // R9
        in_sleep && WDT_CLK_CFG_I == PMWC_WDCK_SYS |-> !WDT_RUN_O)
        else $error("watchdog runs on stopped clock");
    chk_wdt_wake_to: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // R15
        in_sleep && rst_pin_n && WDT_OVF_I && WDT_CLK_CFG_I != PMWC_WDCK_SYS
        |=> TIMEOUT_FLAG_O && (r_r.st == PMWC_START)) else $error("timeout wake wrong");
    chk_reset_wake: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // R13
        in_sleep && !rst_pin_n |=> FULL_RESET_O && (r_r.st == PMWC_RSTDLY))
        else $error("reset wake wrong");
    chk_port_wake: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // R16
        in_sleep && rst_pin_n && !WDT_OVF_I && port_wake |=> r_r.st == PMWC_START)
        else $error("port edge did not wake");
    chk_start_len: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // R20
        $rose(r_r.st == PMWC_START) && (RC_LONG_START || OSC_CFG_I == PMWC_OSC_HXT_CFG)
        |-> !CORE_RUN_O [*8] ##1 !CORE_RUN_O) else $error("start-up too short");
    chk_blocked_irq: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // R19
        in_sleep && rst_pin_n && !WDT_OVF_I && !port_wake && IRQ_FLAG_I == r_r.irq_block
        |=> in_sleep) else $error("pending flag woke device");
    chk_pd_clear: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // R14
        CORE_RUN_O && CLR_WDT_I && !HALT_I |=> !POWERDOWN_FLAG_O)
        else $error("powerdown not cleared");

    // sequences shared by the wake and start-up checks
    sequence s_start_done;
        (r_r.st == PMWC_START) && (r_r.cnt <= 24'h000001);
    endsequence
    sequence s_port_irq_done;
        s_start_done ##0 (r_r.wake_src == PMWC_WK_PORT_INT);
    endsequence
    sequence s_quiet_sleep;
        in_sleep && rst_pin_n && !WDT_OVF_I;
    endsequence
    // mode and oscillator checks
    chk_slow_mode_sel: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // R1
        dual_osc && SYS_CLOCK_SELECT_I |-> OSC_CTL_O.sysclk_slow && !OSC_CTL_O.fast_run)
        else $error("select did not pick slow mode");
    chk_normal_mode: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // R1
        CORE_RUN_O && !SYS_CLOCK_SELECT_I |-> OSC_CTL_O.fast_run && !OSC_CTL_O.sysclk_slow)
        else $error("normal mode lost the fast clock");
    chk_shared_pins: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // R3
        !dual_osc |-> !OSC_CTL_O.slow_xt_run) else $error("slow crystal on shared pins");
    chk_slow_xt_run: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // R5
        dual_osc |-> OSC_CTL_O.slow_xt_run) else $error("slow crystal stopped");
    chk_slow_rc_run: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // R23
        SLOW_RC_EN_I |-> OSC_CTL_O.slow_rc_run) else $error("slow rc stopped");
    chk_lp_write: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // R25
        SLOW_LP_WR_I |=> SLOW_CRYSTAL_LOWPOWER_O == $past(SLOW_LP_VAL_I))
        else $error("low-power bit not written");
    // sleep entry checks
    chk_halt_any_sel: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // R6
        s_halt_taken |=> in_sleep && !CORE_RUN_O) else $error("halt did not stop core");
    chk_wdt_clear_halt: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // R8
        s_halt_taken |-> WDT_CLEAR_O) else $error("watchdog not cleared on halt");
    chk_port_hold: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // R10
        in_sleep |-> PORT_HOLD_O && !CORE_RUN_O) else $error("ports not held in sleep");
    chk_block_load: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // R19
        s_halt_taken |=> r_r.irq_block == $past(IRQ_FLAG_I)) else $error("pending flags lost");
    // wake ordering and pulse checks
    chk_irq_wake: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // R12
        s_quiet_sleep ##0 irq_wake |=> r_r.st == PMWC_START)
        else $error("interrupt did not wake");
    chk_wdt_reset_out: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // R13
        s_start_done ##0 (r_r.wake_src == PMWC_WK_WDT) |=> WDT_RESET_O && !RESUME_O)
        else $error("watchdog wake gave no watchdog reset");
    chk_wdt_keep_pd: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // R15
        in_sleep && rst_pin_n && WDT_OVF_I && WDT_CLK_CFG_I != PMWC_WDCK_SYS
        |=> POWERDOWN_FLAG_O == $past(POWERDOWN_FLAG_O))
        else $error("timeout wake moved flags");
    chk_resume_pulse: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // R16
        s_port_irq_done |=> RESUME_O && CORE_RUN_O && !WDT_RESET_O)
        else $error("port or interrupt wake did not resume");
    chk_masked_irq: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // R17
        s_port_irq_done ##0 (!IRQ_ENABLE_I || STACK_FULL_I) |=> !IRQ_RESPONSE_O)
        else $error("masked interrupt got a response");
    chk_irq_response: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // R18
        s_port_irq_done ##0 (irq_wake && IRQ_ENABLE_I && !STACK_FULL_I) |=> IRQ_RESPONSE_O)
        else $error("enabled interrupt got no response");
    // delay counter checks; the long reset delay is checked step by step
    chk_rst_dly_load: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // R20
        $rose(r_r.st == PMWC_RSTDLY) |-> r_r.cnt == RESET_DLY_CYC)
        else $error("reset delay loaded wrong");
    chk_rst_dly_count: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // R20
        (r_r.st == PMWC_RSTDLY) && (r_r.cnt > 24'h000001)
        |=> (r_r.st == PMWC_RSTDLY) && (r_r.cnt == $past(r_r.cnt) - 24'h000001))
        else $error("reset delay cut short");
    chk_start_load: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // R21 R22 R26
        $rose(r_r.st == PMWC_START) |-> r_r.cnt == ((OSC_CFG_I == PMWC_OSC_HXT_CFG
        || RC_LONG_START) ? 24'(`PMWC_SST_LONG_CYC) : 24'(`PMWC_SST_SHORT_CYC)))
        else $error("start-up length wrong");
endmodule : pmwc_top

//--- pmwc_top_bench.sv
// self-checking bench for the power mode and wake controller
`timescale 1ns/1ps
module pmwc_top_bench;
    import pmwc_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, sel = 1'b0, lp_wr = 1'b0, lp_val = 1'b0;
    logic clr_wdt = 1'b0, irq_en = 1'b0, stk_full = 1'b0, ovf = 1'b0, rc_en = 1'b1;
    logic [7:0] irq_flag = 8'h00, wake_en = 8'h00, port_a;
    logic halt, rst_pin_n, run, slp, hold, wclr, wrun, powerdown_flag, tof, lp, full, wdr, res, irsp;
    logic seen_res, seen_full, seen_wdr, seen_irq, seen_clr;
    pmwc_osc_t osc = PMWC_OSC_RC_XT_CFG;
    pmwc_wdck_t wdck = PMWC_WDCK_SLOW_RC;
    pmwc_osc_ctl_t octl;
    int error_cnt = 0, cmp_count = 0, n;
    always #5 clk = ~clk;
    pmwc_partner u_core (.CLOCK_I(clk), .HALT_O(halt), .PORT_A_O(port_a),
        .RESET_PIN_N_O(rst_pin_n));
    // short reset delay and 2-cycle rc start-up keep the run brief
    pmwc_top #(.RC_LONG_START(1'b0), .RESET_DLY_CYC(24'd20)) DUT (.CLOCK_I(clk),
        .ARST_N_I(arst_n), .OSC_CFG_I(osc), .WDT_CLK_CFG_I(wdck), .SLOW_RC_EN_I(rc_en),
        .SYS_CLOCK_SELECT_I(sel), .SLOW_LP_WR_I(lp_wr), .SLOW_LP_VAL_I(lp_val),
        .CLR_WDT_I(clr_wdt), .HALT_I(halt), .IRQ_FLAG_I(irq_flag), .IRQ_ENABLE_I(irq_en),
        .STACK_FULL_I(stk_full), .WDT_OVF_I(ovf), .EXT_RESET_PIN_N_I(rst_pin_n),
        .PORT_A_I(port_a), .PORT_WAKE_ENABLE_I(wake_en), .OSC_CTL_O(octl),
        .CORE_RUN_O(run), .SLEEPING_O(slp), .PORT_HOLD_O(hold), .WDT_CLEAR_O(wclr),
        .WDT_RUN_O(wrun), .POWERDOWN_FLAG_O(powerdown_flag), .TIMEOUT_FLAG_O(tof),
        .SLOW_CRYSTAL_LOWPOWER_O(lp), .FULL_RESET_O(full), .WDT_RESET_O(wdr),
        .RESUME_O(res), .IRQ_RESPONSE_O(irsp));
    // one-cycle pulses are caught here, so later checks cannot miss them
    always @(posedge clk)
    begin
        if (res) seen_res <= 1'b1;
        if (full) seen_full <= 1'b1;
        if (wdr) seen_wdr <= 1'b1;
        if (irsp) seen_irq <= 1'b1;
        if (wclr) seen_clr <= 1'b1;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        $display("errors %0d of %0d compares", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    // halt and check the sleep entry state one cycle later
    task automatic go_sleep();
        seen_res = 1'b0; seen_full = 1'b0; seen_wdr = 1'b0; seen_irq = 1'b0;
        seen_clr = 1'b0;
        u_core.halt();
        check({slp, powerdown_flag, tof, octl.fast_run, hold, run}, 8'h32);
        check(seen_clr, 1'b1);
    endtask : go_sleep
    // bounded count of cycles until the core runs again
    task automatic wake_time(output int k);
        k = 0;
        while (run !== 1'b1 && k < 3000)
        begin
            @(negedge clk);
            k++;
        end
        // one more edge so the pulse catchers have seen the closing pulse
        @(negedge clk);
    endtask : wake_time
    task automatic pulse_ovf();
        @(negedge clk) ovf = 1'b1;
        @(negedge clk) ovf = 1'b0;
    endtask : pulse_ovf
    initial
    begin
        repeat (10) @(negedge clk);
        arst_n = 1'b1;
        check({run, powerdown_flag, tof, lp}, 4'h8);
        // slow mode in fast rc plus crystal; software sets low-power bit
        sel = 1'b1; lp_wr = 1'b1; lp_val = 1'b1;
        @(negedge clk) lp_wr = 1'b0;
        check({octl.sysclk_slow, octl.fast_run, octl.slow_xt_run, lp}, 4'hb);
        go_sleep();
        check(octl.slow_xt_run, 1'b1);
        wake_en = 8'h08;
        u_core.pin_pulse(3'd0);
        check(slp, 1'b1);
        fork u_core.pin_pulse(3'd3); wake_time(n); join
        check({n >= 2 && n <= 12, seen_res}, 2'h3);
        @(negedge clk) clr_wdt = 1'b1;
        @(negedge clk) clr_wdt = 1'b0;
        check(powerdown_flag, 1'b0);
        // crystal: select ignored, watchdog wake after 1024-cycle start-up
        osc = PMWC_OSC_HXT_CFG;
        @(negedge clk);
        check({octl.sysclk_slow, octl.slow_xt_run, octl.fast_run}, 3'h1);
        go_sleep();
        check({wrun, octl.slow_rc_run}, 2'h3);
        fork pulse_ovf(); wake_time(n); join
        check({tof, powerdown_flag, seen_wdr, n >= 1024 && n <= 1034}, 4'hf);
        // system-clock watchdog stops in sleep; masked irq only resumes
        osc = PMWC_OSC_ERC_CFG; wdck = PMWC_WDCK_SYS; sel = 1'b0;
        go_sleep();
        check(wrun, 1'b0);
        pulse_ovf();
        repeat (4) @(negedge clk);
        check(slp, 1'b1);
        fork irq_flag = 8'h04; wake_time(n); join
        check({seen_res, seen_irq, n >= 2 && n <= 12}, 3'h5);
        // flag pending at entry blocks its own wake; another enabled irq responds
        irq_flag = 8'h01; irq_en = 1'b1;
        go_sleep();
        @(negedge clk) irq_flag = 8'h00;
        @(negedge clk) irq_flag = 8'h01;
        repeat (4) @(negedge clk);
        check(slp, 1'b1);
        fork irq_flag = 8'h03; wake_time(n); join
        check({seen_res, seen_irq}, 2'h3);
        irq_flag = 8'h00;
        // mid-run power-on reset clears powerdown and the low-power bit
        @(negedge clk) arst_n = 1'b0;
        @(negedge clk) arst_n = 1'b1;
        check({run, powerdown_flag, lp}, 3'h4);
        // reset pin wake adds the reset delay before start-up
        go_sleep();
        fork u_core.reset_pulse(); wake_time(n); join
        check({seen_full, n >= 22 && n <= 40}, 2'h3);
        report_and_stop();
    end
    // watchdog: the scenarios take well under 3000 cycles
    initial
    begin
        #200000;
        error_cnt++;
        report_and_stop();
    end
endmodule : pmwc_top_bench
